// *** ccl_pkg.sv ***
// constants and types of the comparator control block
// Summary of operation
// - power-down bit, reset one, disables comparator and DAC
// - raw result one when positive higher or off
// - output enable drives result onto port A bit5 when its mode field is xx10b
// - invert select flips de-bounced result when one
// - trigger mode: rise, fall, both, high level
// - de-bounce none, 4, 8, 16 clocks
// - negative source: pin when zero, DAC when one
// - negative pin select 1,2,reserved,4, else open
// - positive pin select 1,2,3, reserved, else open
package ccl_pkg;
   localparam int ADDR_W = 11;
   localparam logic [8:0] IDX_CONTROL = 9'h18D;
   localparam logic [8:0] IDX_INPUT_SELECT = 9'h18E;
   localparam logic [8:0] IDX_IRQ_STATUS = 9'h190;
   localparam logic [8:0] IDX_IRQ_MASK = 9'h191;
   // control register fields
   localparam int CTL_POWERDOWN = 7;
   localparam int CTL_RAW = 6;
   localparam int CTL_PIN_OE = 5;
   localparam int CTL_INVERT = 4;
   localparam int CTL_TRIG_LO = 2;
   localparam int CTL_DBS_LO = 0;
   localparam logic [7:0] CTL_RESET = 8'h80;
   // input select register fields
   localparam int SEL_NEG_SOURCE = 7;
   localparam int SEL_NEG_PIN_LO = 4;
   localparam int SEL_EMU = 3;
   localparam int SEL_POS_PIN_LO = 0;
   localparam logic [7:0] SEL_RESET = 8'hF7;
   // interrupt registers: bit 0 is the comparator event
   localparam int IRQ_CMP = 0;
   localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
   // de-bounce lengths in system clocks
   localparam logic [4:0] DBS_LEN_1 = 5'h04;
   localparam logic [4:0] DBS_LEN_2 = 5'h08;
   localparam logic [4:0] DBS_LEN_3 = 5'h10;
   // port A bit5 mode pattern xx10b
   localparam logic [1:0] PIN_MODE_CMP = 2'h2;
   typedef enum logic [1:0] {
      CCL_TRIG_RISE,
      CCL_TRIG_FALL,
      CCL_TRIG_BOTH,
      CCL_TRIG_HIGH
   } ccl_trig_t;
   typedef enum logic [1:0] {
      CCL_DBS_NONE,
      CCL_DBS_4,
      CCL_DBS_8,
      CCL_DBS_16
   } ccl_dbs_t;
endpackage

// *** ccl_filter_if.sv ***
// link between the control logic and the de-bounce filter
`timescale 1ns/1ps
`default_nettype none
interface ccl_filter_if;
   import ccl_pkg::*;
   logic raw;
   ccl_dbs_t sel;
   logic filtered;
   modport ctrl (output raw, output sel, input filtered);
   modport filt (input raw, input sel, output filtered);
endinterface
`default_nettype wire

// *** ccl_debounce.sv ***
// de-bounce filter for the raw comparator result
`timescale 1ns/1ps
`default_nettype none
module ccl_debounce
   import ccl_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   ccl_filter_if.filt fi
);
   logic [4:0] count;
   logic [4:0] len;
   logic out;

   always_comb begin
      case (fi.sel)
         CCL_DBS_4: len = DBS_LEN_1;
         CCL_DBS_8: len = DBS_LEN_2;
         CCL_DBS_16: len = DBS_LEN_3;
         default: len = 5'h00;
      endcase
   end

   // counts consecutive cycles the raw level differs from the output
   always_ff @(posedge clk) begin
      if (srst) begin
         count <= 5'h00;
         out <= 1'b1;
      end else if (fi.sel == CCL_DBS_NONE) begin
         count <= 5'h00;
         out <= fi.raw;
      end else if (fi.raw == out) begin
         count <= 5'h00;
      end else if (count + 5'h01 >= len) begin
         count <= 5'h00;
         out <= fi.raw;
      end else begin
         count <= count + 5'h01;
      end
   end

   assign fi.filtered = out;
endmodule
`default_nettype wire

// *** ccl_comparator_top.sv ***
// comparator control: registers, filter, trigger detect, pin and interrupt
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`default_nettype none
module ccl_comparator_top
   import ccl_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic comparator_out,
   output logic analog_powerdown,
   output logic negative_source_select,
   output logic [2:0] negative_pin_select,
   output logic [2:0] positive_pin_select,
   output logic negative_input_from_dac,
   output logic [3:0] negative_external_inputs,
   output logic [2:0] positive_external_inputs,
   input wire logic [3:0] port_a_bit5_mode_field,
   output logic port_a_bit5_pin_out,
   output logic port_a_bit5_pin_oe_n,
   output logic processed_compare_output,
   output logic irq
);
   logic [7:0] control;
   logic [7:0] input_select;
   logic [7:0] irq_status;
   logic [7:0] irq_mask;
   logic ack;
   logic [8:0] idx;
   logic access;
   logic wr_en;
   logic rd_en;
   logic raw_compare_result;
   logic processed;
   logic processed_d;
   logic trig_hit;
   logic [7:0] next_read;
   ccl_trig_t trig_mode;
   ccl_filter_if fi ();

   ccl_debounce u_debounce (
      .clk(clk),
      .srst(srst),
      .fi(fi)
   );

   // bus slave: one wait cycle, then the access completes
   assign idx = avs_address[ADDR_W-1:2];
   assign access = (avs_read | avs_write) & ~ack;
   assign avs_waitrequest = access;
   assign wr_en = avs_write & ack & avs_byteenable[0];
   assign rd_en = avs_read & ack;

   always_ff @(posedge clk) begin
      if (srst) begin
         ack <= 1'b0;
      end else begin
         ack <= access;
      end
   end

   always_comb begin
      next_read = 8'h00;
      case (idx)
         IDX_CONTROL: begin
            next_read = control;
            next_read[CTL_RAW] = raw_compare_result;
         end
         IDX_INPUT_SELECT: next_read = input_select;
         IDX_IRQ_STATUS: next_read = irq_status;
         IDX_IRQ_MASK: next_read = irq_mask;
         default: next_read = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (access) begin
         avs_readdata <= {24'h00_0000, next_read};
      end
   end

   // control register; raw result bit is read-only
   always_ff @(posedge clk) begin
      if (srst) begin
         control <= CTL_RESET;
      end else if (wr_en && idx == IDX_CONTROL) begin
         control <= avs_writedata[7:0] & ~(8'h01 << CTL_RAW);
      end
   end

   // input select register; bit3 is plain storage for emulation use
   always_ff @(posedge clk) begin
      if (srst) begin
         input_select <= SEL_RESET;
      end else if (wr_en && idx == IDX_INPUT_SELECT) begin
         input_select <= avs_writedata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irq_mask <= IRQ_MASK_RESET;
      end else if (wr_en && idx == IDX_IRQ_MASK) begin
         irq_mask <= avs_writedata[7:0];
      end
   end

   // analog controls
   assign analog_powerdown = control[CTL_POWERDOWN];
   assign negative_source_select = input_select[SEL_NEG_SOURCE];
   assign negative_pin_select = input_select[SEL_NEG_PIN_LO +: 3];
   assign positive_pin_select = input_select[SEL_POS_PIN_LO +: 3];
   assign negative_input_from_dac = negative_source_select;

   // one-hot switch enables; bit index n is external input n+1
   always_comb begin
      negative_external_inputs = 4'h0;
      if (!negative_source_select) begin
         case (negative_pin_select)
            3'h0: negative_external_inputs = 4'h1;
            3'h1: negative_external_inputs = 4'h2;
            3'h3: negative_external_inputs = 4'h8;
            default: negative_external_inputs = 4'h0;
         endcase
      end
   end

   always_comb begin
      case (positive_pin_select)
         3'h0: positive_external_inputs = 3'h1;
         3'h1: positive_external_inputs = 3'h2;
         3'h2: positive_external_inputs = 3'h4;
         default: positive_external_inputs = 3'h0;
      endcase
   end

   // result path
   assign raw_compare_result = comparator_out | analog_powerdown;
   assign fi.raw = raw_compare_result;
   assign fi.sel = ccl_dbs_t'(control[CTL_DBS_LO +: 2]);
   assign processed = fi.filtered ^ control[CTL_INVERT];
   assign trig_mode = ccl_trig_t'(control[CTL_TRIG_LO +: 2]);

   // history starts at the idle level after reset (filter 1, no invert), so no false edge
   always_ff @(posedge clk) begin
      if (srst) begin
         processed_d <= 1'b1;
      end else begin
         processed_d <= processed;
      end
   end

   always_comb begin
      case (trig_mode)
         CCL_TRIG_RISE: trig_hit = processed & ~processed_d;
         CCL_TRIG_FALL: trig_hit = ~processed & processed_d;
         CCL_TRIG_BOTH: trig_hit = processed ^ processed_d;
         CCL_TRIG_HIGH: trig_hit = processed;
         default: trig_hit = 1'b0;
      endcase
   end

   // sticky event flag; a read clears only the bits it returned, a new event wins
   always_ff @(posedge clk) begin
      if (srst) begin
         irq_status <= 8'h00;
      end else begin
         if (rd_en && idx == IDX_IRQ_STATUS) begin
            irq_status <= irq_status & ~avs_readdata[7:0];
         end
         if (trig_hit) begin
            irq_status[IRQ_CMP] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
      end
   end

   // port pin output
   always_ff @(posedge clk) begin
      if (srst) begin
         processed_compare_output <= 1'b0;
         port_a_bit5_pin_out <= 1'b0;
         port_a_bit5_pin_oe_n <= 1'b1;
      end else begin
         processed_compare_output <= processed;
         port_a_bit5_pin_out <= processed;
         port_a_bit5_pin_oe_n <= ~(control[CTL_PIN_OE] &&
            port_a_bit5_mode_field[1:0] == PIN_MODE_CMP);
      end
   end
endmodule
`default_nettype wire

// *** ccl_analog_model.sv ***
// analog comparator model driving the raw result
`timescale 1ns/1ps
`default_nettype none
module ccl_analog_model (
   input wire logic clk,
   input wire logic powered_down,
   input wire logic pos_higher,
   output logic cmp_out
);
   logic junk = 1'b0;
   always @(posedge clk) begin
      junk <= ~junk;
   end
   // output of a powered-down comparator is meaningless
   assign cmp_out = powered_down ? junk : pos_higher;
endmodule
`default_nettype wire

// *** ccl_props.sv ***
// assertion checker for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module ccl_props
   import ccl_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic analog_powerdown,
   input wire logic negative_source_select,
   input wire logic [2:0] negative_pin_select,
   input wire logic [2:0] positive_pin_select,
   input wire logic negative_input_from_dac,
   input wire logic [3:0] negative_external_inputs,
   input wire logic [2:0] positive_external_inputs,
   input wire logic [3:0] port_a_bit5_mode_field,
   input wire logic port_a_bit5_pin_oe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence req_rise;
      $rose(avs_read || avs_write);
   endsequence
   sequence ack_next;
      ##1 !avs_waitrequest;
   endsequence
   req_wait_a: assert property (req_rise |-> avs_waitrequest) else $error("no wait on new request");
   req_ack_a: assert property (req_rise |-> ack_next) else $error("late bus answer");
   idle_wait_a: assert property (!avs_read && !avs_write |-> !avs_waitrequest) else $error("wait while idle");
   pd_raw_a: assert property (
      avs_read && !avs_waitrequest && avs_address[10:2] == IDX_CONTROL && analog_powerdown
      |-> avs_readdata[CTL_RAW]) else $error("raw bit low in powerdown");
   dac_sel_a: assert property (
      negative_source_select |-> negative_input_from_dac && negative_external_inputs == 4'h0)
      else $error("pin switch on with dac source");
   neg_pin_a: assert property (
      !negative_source_select |-> negative_external_inputs == (negative_pin_select == 3'h0 ? 4'h1 :
      negative_pin_select == 3'h1 ? 4'h2 : negative_pin_select == 3'h3 ? 4'h8 : 4'h0))
      else $error("bad negative switch");
   pos_pin_a: assert property (
      positive_external_inputs == (positive_pin_select[2] || positive_pin_select == 3'h3 ? 3'h0 :
      3'h1 << positive_pin_select[1:0])) else $error("bad positive switch");
   oe_mode_a: assert property (
      !port_a_bit5_pin_oe_n |-> $past(port_a_bit5_mode_field[1:0]) == PIN_MODE_CMP)
      else $error("pin driven in wrong mode");
endmodule
bind ccl_comparator_top ccl_props props_i (.clk, .srst, .avs_address, .avs_read, .avs_write, .avs_readdata,
   .avs_waitrequest, .analog_powerdown, .negative_source_select, .negative_pin_select, .positive_pin_select,
   .negative_input_from_dac, .negative_external_inputs, .positive_external_inputs, .port_a_bit5_mode_field,
   .port_a_bit5_pin_oe_n);
`default_nettype wire

// *** comparator_control_logic_tb_top.sv ***
// self-checking bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; $display("mismatch t=%0t %h %h", $time, a, b); end end
module comparator_control_logic_tb_top;
   import ccl_pkg::*;
   localparam logic [3:0] RISE = 4'hD;
   localparam logic [3:0] FALL = 4'hE;
   logic clk = 0, srst = 1, rd = 0, wr = 0, gt = 0, w, pd, cmp, oe_n, pin, po, irq;
   logic [ADDR_W-1:0] adr = '0;
   logic [31:0] wd = '0, rdat, q;
   logic [3:0] mode = '0;
   logic dac, nss;
   logic [2:0] nps, pps, psw;
   logic [3:0] nsw;
   int n_errors = 0, n_checks = 0;
   always #20 clk = ~clk;
   ccl_comparator_top uut (.clk, .srst, .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(w), .comparator_out(cmp),
      .analog_powerdown(pd), .negative_source_select(nss), .negative_pin_select(nps), .positive_pin_select(pps),
      .negative_input_from_dac(dac), .negative_external_inputs(nsw), .positive_external_inputs(psw),
      .port_a_bit5_mode_field(mode), .port_a_bit5_pin_out(pin), .port_a_bit5_pin_oe_n(oe_n),
      .processed_compare_output(po), .irq(irq));
   ccl_analog_model cmp_i (.clk, .powered_down(pd), .pos_higher(gt), .cmp_out(cmp));
   task automatic acc(input bit we, input logic [8:0] idx, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge clk);
      adr <= {idx, 2'h0};
      wd <= {24'h0, d};
      rd <= !we;
      wr <= we;
      do begin
         @(posedge clk);
         k++;
      end while (w !== 1'b0 && k < 50);
      q = rdat;
      rd <= 0;
      wr <= 0;
      if (k >= 50) n_errors++;
   endtask
   task automatic rchk(input logic [8:0] idx, input logic [7:0] e);
      acc(0, idx, 8'h00);
      `CHK(q[7:0], e)
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic set_gt(input logic v);
      @(posedge clk);
      gt <= v;
   endtask
   task automatic t_reset();
      rchk(IDX_CONTROL, 8'hC0);
      rchk(IDX_INPUT_SELECT, SEL_RESET);
      acc(1, 9'h100, 8'h5A);
      rchk(9'h100, 8'h00);
      rchk(IDX_IRQ_STATUS, 8'h00);
   endtask
   task automatic t_raw();
      acc(1, IDX_CONTROL, 8'h00);
      cyc(4);
      `CHK(pd, 1'b0)
      rchk(IDX_CONTROL, 8'h00);
      set_gt(1);
      cyc(4);
      rchk(IDX_CONTROL, 8'h40);
   endtask
   task automatic t_dbs();
      int lens[4];
      int k;
      lens = '{1, DBS_LEN_1, DBS_LEN_2, DBS_LEN_3};
      for (int c = 0; c < 4; c++) begin
         acc(1, IDX_CONTROL, 8'(c));
         set_gt(0);
         cyc(40);
         set_gt(1);
         cyc(lens[c] - 2);
         set_gt(0);
         cyc(20);
         if (c > 0) `CHK(po, 1'b0)
         set_gt(1);
         k = 0;
         do begin
            @(posedge clk);
            #1;
            k++;
         end while (po !== 1'b1 && k < 40);
         `CHK(k, lens[c] + 1)
      end
   endtask
   task automatic t_trig();
      acc(1, IDX_IRQ_MASK, 8'h01);
      for (int m = 0; m < 4; m++) begin
         acc(1, IDX_CONTROL, 8'(m << 2));
         set_gt(0);
         cyc(6);
         acc(0, IDX_IRQ_STATUS, 8'h00);
         set_gt(1);
         cyc(6);
         `CHK(irq, RISE[m])
         rchk(IDX_IRQ_STATUS, {7'h00, RISE[m]});
         set_gt(0);
         cyc(6);
         rchk(IDX_IRQ_STATUS, {7'h00, FALL[m]});
         cyc(2);
         `CHK(irq, 1'b0)
      end
      acc(1, IDX_IRQ_MASK, 8'h00);
      set_gt(1);
      cyc(6);
      `CHK(irq, 1'b0)
      rchk(IDX_IRQ_STATUS, 8'h01);
   endtask
   task automatic t_pin();
      set_gt(0);
      mode <= 4'h2;
      acc(1, IDX_CONTROL, 8'h30);
      cyc(6);
      `CHK(po, 1'b1)
      `CHK(oe_n, 1'b0)
      `CHK(pin, 1'b1)
      @(posedge clk);
      mode <= 4'h0;
      cyc(3);
      `CHK(oe_n, 1'b1)
   endtask
   task automatic t_sel();
      logic [3:0] nexp[8];
      logic [2:0] pexp[8];
      nexp = '{4'h1, 4'h2, 4'h0, 4'h8, 4'h0, 4'h0, 4'h0, 4'h0};
      pexp = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
      for (int i = 0; i < 8; i++) begin
         acc(1, IDX_INPUT_SELECT, {1'b0, 3'(i), 1'b1, 3'(i)});
         cyc(1);
         `CHK(nsw, nexp[i])
         `CHK(psw, pexp[i])
         `CHK(nps, 3'(i))
         `CHK(pps, 3'(i))
      end
      rchk(IDX_INPUT_SELECT, 8'h7F);
      acc(1, IDX_INPUT_SELECT, 8'h88);
      cyc(1);
      `CHK(nss, 1'b1)
      `CHK(dac, 1'b1)
      `CHK(nsw, 4'h0)
      `CHK(psw, 3'h1)
   endtask
   task automatic end_sim();
      $display("errors %0d checks %0d", n_errors, n_checks);
      if (n_errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      end_sim();
   end
   initial begin
      repeat (4) @(posedge clk);
      srst <= 0;
      t_reset();
      t_raw();
      t_dbs();
      t_trig();
      t_pin();
      t_sel();
      end_sim();
   end
endmodule
`default_nettype wire
